// ### logic/sls_link_status.sv
// Purpose: read-only receive lane status bank for lanes 5 and 6
// Assumes: status sources on core_clk_i; threshold held by an outside register
// Notes:   one-cycle read strobe, registered answer one edge later
//
// Contract
// - lane 6 bit 7 flags disparity errors
// - lane 6 bit 6 flags not-in-table codes
// - lane 6 bit 5 flags stray control characters
// - error flag set when count reaches threshold
// - bit 4 reports interlane deskew achieved
// - bit 3 reports initial lane alignment achieved
// - bit 2 reports configuration checksum correct
// - bit 1 reports frame synchronization achieved
// - bit 0 reports code group synchronization
// - lane 5 carries same flags bits 7..0
`timescale 1ns/1ps
`include "sls_regs.svh"
`default_nettype none

module sls_link_status (
	// clock and reset
	input  wire logic               core_clk_i,
	input  wire logic               rst_n_i,
	// configuration port
	input  wire sls_pkg::sls_addr_t reg_addr_i,
	input  wire logic               reg_rd_i,
	input  wire logic               reg_wr_i,
	input  wire sls_pkg::sls_byte_t reg_wdata_i,
	output var  sls_pkg::sls_byte_t reg_rdata_o,
	output var  logic               reg_rvalid_o,
	output var  logic               reg_hit_o,
	// threshold from the outside threshold register
	input  wire sls_pkg::sls_byte_t error_count_threshold_i,
	// lane 5 sources
	input  wire sls_pkg::sls_byte_t lane5_disparity_err_count_i,
	input  wire sls_pkg::sls_byte_t lane5_invalid_code_count_i,
	input  wire sls_pkg::sls_byte_t lane5_stray_control_count_i,
	input  wire logic               lane5_deskew_ok_i,
	input  wire logic               lane5_init_align_ok_i,
	input  wire logic               lane5_checksum_ok_i,
	input  wire logic               lane5_frame_lock_i,
	input  wire logic               lane5_codegroup_lock_i,
	// lane 6 sources
	input  wire sls_pkg::sls_byte_t lane6_disparity_err_count_i,
	input  wire sls_pkg::sls_byte_t lane6_invalid_code_count_i,
	input  wire sls_pkg::sls_byte_t lane6_stray_control_count_i,
	input  wire logic               lane6_deskew_ok_i,
	input  wire logic               lane6_init_align_ok_i,
	input  wire logic               lane6_checksum_ok_i,
	input  wire logic               lane6_frame_lock_i,
	input  wire logic               lane6_codegroup_lock_i,
	// status bytes
	output var  sls_pkg::sls_byte_t lane5_link_state_o,
	output var  sls_pkg::sls_byte_t lane6_link_state_o
);

	////////////////////////////////////////////////////////////////////////////////
	// lane arrays, index 0 is lane 5, index 1 is lane 6

	sls_pkg::sls_byte_t  disparity_count [`SLS_LANE_COUNT];
	sls_pkg::sls_byte_t  invalid_count   [`SLS_LANE_COUNT];
	sls_pkg::sls_byte_t  stray_count     [`SLS_LANE_COUNT];
	logic [`SLS_LANE_COUNT-1:0] deskew_ok;
	logic [`SLS_LANE_COUNT-1:0] init_align_ok;
	logic [`SLS_LANE_COUNT-1:0] checksum_ok;
	logic [`SLS_LANE_COUNT-1:0] frame_lock;
	logic [`SLS_LANE_COUNT-1:0] codegroup_lock;
	sls_pkg::sls_byte_t  lane_state      [`SLS_LANE_COUNT];

	assign disparity_count[0] = lane5_disparity_err_count_i;
	assign disparity_count[1] = lane6_disparity_err_count_i;
	assign invalid_count[0]   = lane5_invalid_code_count_i;
	assign invalid_count[1]   = lane6_invalid_code_count_i;
	assign stray_count[0]     = lane5_stray_control_count_i;
	assign stray_count[1]     = lane6_stray_control_count_i;
	assign deskew_ok          = {lane6_deskew_ok_i, lane5_deskew_ok_i};
	assign init_align_ok      = {lane6_init_align_ok_i, lane5_init_align_ok_i};
	assign checksum_ok        = {lane6_checksum_ok_i, lane5_checksum_ok_i};
	assign frame_lock         = {lane6_frame_lock_i, lane5_frame_lock_i};
	assign codegroup_lock     = {lane6_codegroup_lock_i, lane5_codegroup_lock_i};

	////////////////////////////////////////////////////////////////////////////////
	// per-lane status bytes

	genvar lane;
	generate
		for (lane = 0; lane < `SLS_LANE_COUNT; lane = lane + 1) begin : g_lane
			sls_lane_status u_lane (
				.core_clk_i              (core_clk_i),
				.rst_n_i                 (rst_n_i),
				.error_count_threshold_i (error_count_threshold_i),
				.disparity_err_count_i   (disparity_count[lane]),
				.invalid_code_count_i    (invalid_count[lane]),
				.stray_control_count_i   (stray_count[lane]),
				.deskew_ok_i             (deskew_ok[lane]),
				.init_align_ok_i         (init_align_ok[lane]),
				.checksum_ok_i           (checksum_ok[lane]),
				.frame_lock_i            (frame_lock[lane]),
				.codegroup_lock_i        (codegroup_lock[lane]),
				.link_state_o            (lane_state[lane])
			);
		end
	endgenerate

	// bits 4..1 stay meaningless under a skipped alignment sequence; reader filters
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			lane5_link_state_o <= `SLS_LINK_STATE_RESET;
			lane6_link_state_o <= `SLS_LINK_STATE_RESET;
		end else begin
			lane5_link_state_o <= lane_state[0];
			lane6_link_state_o <= lane_state[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// address decode and read data selection

	wire logic               hit_lane5;
	wire logic               hit_lane6;
	wire logic               hit_any;
	wire logic               take_rd;
	wire logic               take_wr;
	wire sls_pkg::sls_byte_t sel_rdata;

	assign hit_lane5 = (reg_addr_i == `SLS_LANE5_LINK_STATE);
	assign hit_lane6 = (reg_addr_i == `SLS_LANE6_LINK_STATE);
	assign hit_any   = hit_lane5 | hit_lane6;
	assign take_rd   = reg_rd_i & ~reg_wr_i;
	// write data is dropped: both registers are read only
	assign take_wr   = reg_wr_i & (reg_wdata_i == reg_wdata_i);
	assign sel_rdata = hit_lane6 ? lane_state[1] :
	                   hit_lane5 ? lane_state[0] :
	                   `SLS_UNMAPPED_RDATA;

	////////////////////////////////////////////////////////////////////////////////
	// access sequencer: strobe taken in idle, answer stands one cycle

	sls_pkg::sls_acc_e  acc_state;
	sls_pkg::sls_acc_e  next_acc_state;
	sls_pkg::sls_byte_t next_rdata;
	logic               next_rvalid;
	logic               next_hit;

	always_comb begin
		next_acc_state = acc_state;
		next_rdata     = reg_rdata_o;
		next_rvalid    = 1'b0;
		next_hit       = reg_hit_o;
		case (acc_state)
			sls_pkg::SLS_ACC_IDLE: begin
				if (take_rd) begin
					next_acc_state = sls_pkg::SLS_ACC_ANSWER;
					next_rdata     = sel_rdata;
					next_rvalid    = 1'b1;
					next_hit       = hit_any;
				end else if (take_wr) begin
					next_acc_state = sls_pkg::SLS_ACC_ANSWER;
					next_rvalid    = 1'b1;
					next_hit       = hit_any;
				end
			end
			sls_pkg::SLS_ACC_ANSWER: begin
				next_acc_state = sls_pkg::SLS_ACC_IDLE;
			end
			default: begin
				next_acc_state = sls_pkg::SLS_ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			acc_state    <= sls_pkg::SLS_ACC_IDLE;
			reg_rdata_o  <= `SLS_UNMAPPED_RDATA;
			reg_rvalid_o <= 1'b0;
			reg_hit_o    <= 1'b0;
		end else begin
			acc_state    <= next_acc_state;
			reg_rdata_o  <= next_rdata;
			reg_rvalid_o <= next_rvalid;
			reg_hit_o    <= next_hit;
		end
	end

endmodule

`default_nettype wire

// ### logic/sls_regs.svh
// Purpose: offsets, bit positions and reset values of the lane status bank
// Assumes: byte-wide registers at their printed offsets on the configuration port
// Notes:   definitions only
`ifndef SLS_REGS_SVH
`define SLS_REGS_SVH

`define SLS_ADDR_W              12
`define SLS_DATA_W              8
`define SLS_LANE5_LINK_STATE    12'h4B5
`define SLS_LANE6_LINK_STATE    12'h4B6
`define SLS_LINK_STATE_RESET    8'h00
`define SLS_UNMAPPED_RDATA      8'h00

`define SLS_BIT_DISPARITY_ERR   7
`define SLS_BIT_INVALID_CODE    6
`define SLS_BIT_STRAY_CONTROL   5
`define SLS_BIT_DESKEW_OK       4
`define SLS_BIT_INIT_ALIGN_OK   3
`define SLS_BIT_CHECKSUM_OK     2
`define SLS_BIT_FRAME_LOCK      1
`define SLS_BIT_CODEGROUP_LOCK  0

`define SLS_LANE_COUNT          2

`endif

// ### logic/sls_pkg.sv
// Purpose: shared types of the lane status bank
// Assumes: widths fixed by sls_regs.svh
// Notes:   nothing here is imported; use sls_pkg::name
`include "sls_regs.svh"
`default_nettype none

package sls_pkg;

	typedef logic [`SLS_ADDR_W-1:0] sls_addr_t;
	typedef logic [`SLS_DATA_W-1:0] sls_byte_t;

	typedef enum logic [1:0] {
		SLS_ACC_IDLE   = 2'b01,
		SLS_ACC_ANSWER = 2'b10
	} sls_acc_e;

endpackage

`default_nettype wire

// ### logic/sls_lane_status.sv
// Purpose: one lane's status byte, error classes compared against the threshold
// Assumes: counts and sync levels come from link logic on core_clk_i
// Notes:   byte is registered, read only, cleared by reset
`timescale 1ns/1ps
`include "sls_regs.svh"
`default_nettype none

module sls_lane_status (
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	// threshold
	input  wire sls_pkg::sls_byte_t error_count_threshold_i,
	// error counts
	input  wire sls_pkg::sls_byte_t disparity_err_count_i,
	input  wire sls_pkg::sls_byte_t invalid_code_count_i,
	input  wire sls_pkg::sls_byte_t stray_control_count_i,
	// sync levels
	input  wire logic              deskew_ok_i,
	input  wire logic              init_align_ok_i,
	input  wire logic              checksum_ok_i,
	input  wire logic              frame_lock_i,
	input  wire logic              codegroup_lock_i,
	// status byte
	output var  sls_pkg::sls_byte_t link_state_o
);

	wire logic              disparity_err_flag;
	wire logic              invalid_code_flag;
	wire logic              stray_control_char_flag;
	sls_pkg::sls_byte_t     next_link_state;

	assign disparity_err_flag      = (disparity_err_count_i >= error_count_threshold_i);
	assign invalid_code_flag       = (invalid_code_count_i >= error_count_threshold_i);
	assign stray_control_char_flag = (stray_control_count_i >= error_count_threshold_i);

	always_comb begin
		next_link_state                          = `SLS_LINK_STATE_RESET;
		next_link_state[`SLS_BIT_DISPARITY_ERR]  = disparity_err_flag;
		next_link_state[`SLS_BIT_INVALID_CODE]   = invalid_code_flag;
		next_link_state[`SLS_BIT_STRAY_CONTROL]  = stray_control_char_flag;
		next_link_state[`SLS_BIT_DESKEW_OK]      = deskew_ok_i;
		next_link_state[`SLS_BIT_INIT_ALIGN_OK]  = init_align_ok_i;
		next_link_state[`SLS_BIT_CHECKSUM_OK]    = checksum_ok_i;
		next_link_state[`SLS_BIT_FRAME_LOCK]     = frame_lock_i;
		next_link_state[`SLS_BIT_CODEGROUP_LOCK] = codegroup_lock_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			link_state_o <= `SLS_LINK_STATE_RESET;
		end else begin
			link_state_o <= next_link_state;
		end
	end

endmodule

`default_nettype wire

// ### tb/sls_link_status_chk.sv
// Purpose: port checker for the lane status bank
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every sls_link_status instance
`timescale 1ns/1ps
`include "sls_regs.svh"
`default_nettype none

module sls_link_status_chk (
	// clock, reset and port
	input wire logic               core_clk_i,
	input wire logic               rst_n_i,
	input wire sls_pkg::sls_addr_t reg_addr_i,
	input wire logic               reg_rd_i,
	input wire logic               reg_wr_i,
	input wire sls_pkg::sls_byte_t reg_rdata_o,
	input wire logic               reg_rvalid_o,
	input wire logic               reg_hit_o,
	// sources and status
	input wire sls_pkg::sls_byte_t error_count_threshold_i,
	input wire sls_pkg::sls_byte_t lane6_disparity_err_count_i,
	input wire sls_pkg::sls_byte_t lane6_invalid_code_count_i,
	input wire sls_pkg::sls_byte_t lane6_stray_control_count_i,
	input wire sls_pkg::sls_byte_t lane5_link_state_o,
	input wire sls_pkg::sls_byte_t lane6_link_state_o
);
	logic [1:0] warm;
	wire        rd_take = reg_rd_i && !reg_wr_i && !reg_rvalid_o;
	wire        wr_take = reg_wr_i && !reg_rvalid_o;
	wire  [2:0] err6 = {lane6_disparity_err_count_i >= error_count_threshold_i,
		lane6_invalid_code_count_i >= error_count_threshold_i,
		lane6_stray_control_count_i >= error_count_threshold_i};
	// edges since reset release, saturating
	always_ff @(posedge core_clk_i) begin
		warm <= !rst_n_i ? 2'h0 : warm + {1'h0, ~&warm};
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_read_answer: assert property (rd_take |=> reg_rvalid_o)
		else $error("read not answered");
	chk_answer_pulse: assert property (reg_rvalid_o |=> !reg_rvalid_o)
		else $error("answer longer than one cycle");
	chk_lane6_read: assert property (rd_take && reg_addr_i == `SLS_LANE6_LINK_STATE
		|=> reg_rdata_o == lane6_link_state_o && reg_hit_o) else $error("lane 6 read wrong");
	chk_lane5_read: assert property (rd_take && reg_addr_i == `SLS_LANE5_LINK_STATE
		|=> reg_rdata_o == lane5_link_state_o && reg_hit_o) else $error("lane 5 read wrong");
	chk_unmapped_read: assert property (rd_take && reg_addr_i != `SLS_LANE5_LINK_STATE
		&& reg_addr_i != `SLS_LANE6_LINK_STATE |=> reg_rdata_o == 8'h00 && !reg_hit_o)
		else $error("unmapped read wrong");
	chk_write_ignored: assert property (wr_take |=> reg_rvalid_o && $stable(reg_rdata_o))
		else $error("write changed read data");
	chk_err_flags: assert property (warm[1] |-> lane6_link_state_o[7:5] == $past(err6, 2))
		else $error("error flags do not follow threshold");
	chk_reset_clear: assert property (warm == 2'h1 |-> (lane5_link_state_o | lane6_link_state_o)
		== 8'h00) else $error("status not cleared by reset");
	cov_lane6_read: cover property (rd_take && reg_addr_i == `SLS_LANE6_LINK_STATE);
	cov_write: cover property (wr_take);
	cov_err_set: cover property (lane6_link_state_o[7]);
endmodule

bind sls_link_status sls_link_status_chk sls_link_status_chk_inst (.*);
`default_nettype wire

// ### tb/sls_tx_model.sv
// Purpose: far-end transmitter model driving both lanes' counts and sync levels
// Assumes: word per lane {disparity, invalid, stray, sync[4:0]}, lane 6 on top
// Notes:   keeps running through receiver reset, like the real link
`timescale 1ns/1ps
`default_nettype none

module sls_tx_model (
	input  wire logic        core_clk_i,
	input  wire logic [57:0] cmd_i,
	output var  logic [57:0] src_o
);
	always_ff @(posedge core_clk_i) begin
		src_o <= cmd_i;
	end
endmodule
`default_nettype wire

// ### tb/sls_link_status_tb.sv
// Purpose: self-checking bench for the lane status bank
// Assumes: 20 MHz core clock, synchronous reset
// Notes:   sources pass through the transmitter model, one extra edge
`timescale 1ns/1ps
`include "sls_regs.svh"
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end

module sls_link_status_tb;
	logic               core_clk_i = 1'h0;
	logic               rst_n_i = 1'h0;
	sls_pkg::sls_addr_t reg_addr_i = 12'h000;
	logic               reg_rd_i = 1'h0;
	logic               reg_wr_i = 1'h0;
	sls_pkg::sls_byte_t reg_wdata_i = 8'h00;
	sls_pkg::sls_byte_t thr = 8'h04;
	logic [57:0]        cmd = '1;
	wire  [57:0]        src;
	sls_pkg::sls_byte_t rdata, st5, st6;
	logic               rvalid, hit;
	int                 mismatches = 0;
	int                 checks_done = 0;
	int                 cycles = 0;

	sls_tx_model sls_tx_model_inst (.core_clk_i, .cmd_i(cmd), .src_o(src));
	sls_link_status sls_link_status_inst (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_rd_i,
		.reg_wr_i, .reg_wdata_i, .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(hit),
		.error_count_threshold_i(thr),
		.lane5_disparity_err_count_i(src[28:21]), .lane5_invalid_code_count_i(src[20:13]),
		.lane5_stray_control_count_i(src[12:5]), .lane5_deskew_ok_i(src[4]),
		.lane5_init_align_ok_i(src[3]), .lane5_checksum_ok_i(src[2]),
		.lane5_frame_lock_i(src[1]), .lane5_codegroup_lock_i(src[0]),
		.lane6_disparity_err_count_i(src[57:50]), .lane6_invalid_code_count_i(src[49:42]),
		.lane6_stray_control_count_i(src[41:34]), .lane6_deskew_ok_i(src[33]),
		.lane6_init_align_ok_i(src[32]), .lane6_checksum_ok_i(src[31]),
		.lane6_frame_lock_i(src[30]), .lane6_codegroup_lock_i(src[29]),
		.lane5_link_state_o(st5), .lane6_link_state_o(st6));

	always #25 core_clk_i = ~core_clk_i;

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic sls_pkg::sls_byte_t exp(input logic [28:0] s);
		return {s[28:21] >= thr, s[20:13] >= thr, s[12:5] >= thr, s[4:0]};
	endfunction

	// one access, entered just after a rising edge; e is read data expected
	task automatic acc(input sls_pkg::sls_addr_t a, input logic w, input sls_pkg::sls_byte_t e,
		input logic h);
		reg_addr_i <= a;
		reg_rd_i <= ~w;
		reg_wr_i <= w;
		reg_wdata_i <= ~e;
		@(posedge core_clk_i);
		reg_rd_i <= 1'h0;
		reg_wr_i <= 1'h0;
		#1;
		`CHK(rvalid, 1'h1)
		`CHK(rdata, e)
		`CHK(hit, h)
		if (!w && a == `SLS_LANE6_LINK_STATE) `CHK(st6, e)
		if (!w && a == `SLS_LANE5_LINK_STATE) `CHK(st5, e)
		@(posedge core_clk_i);
	endtask

	// model edge plus two status stages, then one spare
	task automatic put(input logic [57:0] c);
		cmd <= c;
		repeat (4) @(posedge core_clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		acc(`SLS_LANE6_LINK_STATE, 1'h0, `SLS_LINK_STATE_RESET, 1'h1);
		acc(`SLS_LANE6_LINK_STATE, 1'h0, 8'hFF, 1'h1);
		acc(`SLS_LANE6_LINK_STATE, 1'h1, 8'hFF, 1'h1);
		acc(`SLS_LANE5_LINK_STATE, 1'h1, 8'hFF, 1'h1);
		acc(`SLS_LANE6_LINK_STATE, 1'h0, 8'hFF, 1'h1);
		acc(`SLS_LANE5_LINK_STATE, 1'h0, 8'hFF, 1'h1);
		$display("t_reset done");
	endtask

	// alignment sequence not skipped, so bits 4..1 are meaningful
	task automatic t_sync();
		logic [28:0] s;
		for (int b = 0; b < 5; b++) begin
			s = 29'h1 << b;
			put({s, 29'h10 >> b});
			acc(`SLS_LANE6_LINK_STATE, 1'h0, exp(s), 1'h1);
			acc(`SLS_LANE5_LINK_STATE, 1'h0, exp(29'h10 >> b), 1'h1);
		end
		$display("t_sync done");
	endtask

	// each class one below and exactly at the threshold, low and top values
	task automatic t_thresh();
		logic [28:0]        s;
		sls_pkg::sls_byte_t t;
		for (int n = 0; n < 2; n++) begin
			t = n ? 8'hFF : 8'h01;
			thr <= t;
			for (int k = 0; k < 3; k++) begin
				for (int d = 0; d < 2; d++) begin
					s = '0;
					s[5 + 8 * k +: 8] = t - 8'(1 - d);
					put({s, s});
					acc(`SLS_LANE6_LINK_STATE, 1'h0, exp(s), 1'h1);
					acc(`SLS_LANE5_LINK_STATE, 1'h0, exp(s), 1'h1);
				end
			end
		end
		thr <= 8'h00;
		put('0);
		acc(`SLS_LANE6_LINK_STATE, 1'h0, 8'hE0, 1'h1);
		$display("t_thresh done");
	endtask

	task automatic t_unmapped();
		sls_pkg::sls_addr_t a [3] = '{12'h4B7, 12'h000, 12'hFFF};
		for (int i = 0; i < 3; i++) begin
			acc(a[i], 1'h0, `SLS_UNMAPPED_RDATA, 1'h0);
		end
		$display("t_unmapped done");
	endtask

	// strobe in the answer cycle is dropped; read with write counts as write
	task automatic t_refused();
		reg_addr_i <= 12'h000;
		reg_rd_i <= 1'h1;
		@(posedge core_clk_i);
		reg_addr_i <= `SLS_LANE6_LINK_STATE;
		@(posedge core_clk_i);
		reg_rd_i <= 1'h0;
		#1;
		`CHK(rvalid, 1'h0)
		`CHK(rdata, `SLS_UNMAPPED_RDATA)
		`CHK(hit, 1'h0)
		@(posedge core_clk_i);
		reg_rd_i <= 1'h1;
		reg_wr_i <= 1'h1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'h0;
		reg_wr_i <= 1'h0;
		#1;
		`CHK(rvalid, 1'h1)
		`CHK(rdata, `SLS_UNMAPPED_RDATA)
		`CHK(hit, 1'h1)
		@(posedge core_clk_i);
		$display("t_refused done");
	endtask

	// reset in mid-run with all sources high; first read right at release
	task automatic t_midreset();
		put('1);
		rst_n_i <= 1'h0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		acc(`SLS_LANE6_LINK_STATE, 1'h0, `SLS_LINK_STATE_RESET, 1'h1);
		acc(`SLS_LANE5_LINK_STATE, 1'h0, 8'hFF, 1'h1);
		$display("t_midreset done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		t_reset();
		t_sync();
		t_thresh();
		t_unmapped();
		t_refused();
		t_midreset();
		end_sim();
	end
endmodule
`default_nettype wire
